// *** design/cpu_standby_wake_control.sv ***
// reset, standby, wake, halt and wait sequencer with apb registers
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps

// What this block does
// - reset input low stops core, ignores wakes
// - reset enables irqs, unmasks keys, clears status
// - reset floats bus, float flag and precharge high
// - sleep issues sleep command, then stops
// - standby keeps reset port states and state
// - latch wakes only asleep, deferred while halted
// - level sources need interval; on-key edge wakes
// - raise clock request, await fast oscillator pulses
// - reset in standby gives reset command
// - then program counter broadcast, then fetch
// - key wake takes interrupt before first fetch
// - level wake after full interval; early on-key edge ignored
// - request supply, run only after permission
// - timer running: abandon wake after timeout
// - halt finishes instruction then idles bus floated
// - halted ignores irqs; pending taken after halt
// - wait high in strobe-low phase freezes bus condition
// - twelve-bit write-only output register, bits 9-10 dropped
// - output pad precharge in last instruction cycle
// - sixteen-bit input register, bits 9-14 zero
// - precharge request pulses low before strobe
module cpu_standby_wake_control #(
  parameter int WAKE_TIMEOUT_CYCLES = standby_wake_pkg::WAKE_TIMEOUT_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RESET_IN_N_I,
  input wire logic HALT_REQUEST_I,
  input wire logic WAIT_REQUEST_I,
  input wire logic KEY_DOWN_EVENT_I,
  input wire logic BURNIN_WAKE_I,
  input wire logic COMMAND_DATA_SELECT_I,
  input wire logic ON_KEY_INPUT_I,
  input wire logic FAST_OSC_PULSES_I,
  input wire logic SUPPLY_READY_I,
  input wire logic TIMER_RUNNING_I,
  input wire logic SLEEP_INSTRUCTION_I,
  input wire logic INSTR_LAST_I,
  input wire logic [8:0] KEY_SENSE_LINES_I,
  output logic STROBE_OUT_N_O,
  output logic STROBE_OE_O,
  output logic CMD_DATA_OUT_N_O,
  output logic CMD_DATA_OE_O,
  output logic [3:0] NIBBLE_BUS_LINES_O,
  output logic NIBBLE_BUS_OE_O,
  output logic BUS_FLOAT_O,
  output logic BUS_PRECHARGE_N_O,
  output logic CLOCK_REQUEST_O,
  output logic KEY_POLL_ENABLE_N_O,
  output logic SLEEP_INDICATOR_O,
  output logic WAKE_REQUEST_O,
  output logic IRQ_TAKE_O,
  output logic PC_CLEAR_O,
  output logic HEX_MODE_O,
  output logic KEY_IRQ_UNMASK_O,
  output logic INT_ENABLE_O,
  output logic [2:0] RETURN_STACK_PTR_O,
  output logic [11:0] OUT_REG_O,
  output logic OUT_PRECHARGE_O
);

  standby_wake_pkg::ctl_t q;
  standby_wake_pkg::ctl_t d;
  logic lvl_src;
  logic on_edge;
  logic irq_src;
  logic bus_step;
  logic apb_wr;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // states that run a two-phase bus cycle
  function automatic logic bus_state(input standby_wake_pkg::state_t s);
    bus_state = (s == standby_wake_pkg::ST_RUN) || (s == standby_wake_pkg::ST_SLEEP_CMD) ||
                (s == standby_wake_pkg::ST_FIRST_CMD) || (s == standby_wake_pkg::ST_PC_CMD);
  endfunction : bus_state

  // nibble command driven by a command state
  function automatic logic [3:0] cmd_code(input standby_wake_pkg::state_t s, input logic rs);
    case (s)
      standby_wake_pkg::ST_SLEEP_CMD: cmd_code = standby_wake_pkg::CMD_SLEEP;
      standby_wake_pkg::ST_PC_CMD: cmd_code = standby_wake_pkg::CMD_PC_LOAD;
      default: cmd_code = rs ? standby_wake_pkg::CMD_RESET : standby_wake_pkg::CMD_NOP;
    endcase
  endfunction : cmd_code

  ////////////////////////////////////////////////////////////////////////////
  // wake source decode
  // command/data wake is taken as active while the line is low
  assign lvl_src = KEY_DOWN_EVENT_I | BURNIN_WAKE_I | ~COMMAND_DATA_SELECT_I;
  assign on_edge = ON_KEY_INPUT_I & ~q.on_key_prev;
  assign irq_src = (q.woke_on_key & ON_KEY_INPUT_I) |
                   (KEY_DOWN_EVENT_I & q.key_irq_unmask & q.int_enable & ~q.key_sm_busy);
  assign bus_step = ~(q.phase & WAIT_REQUEST_I);
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I & q.pready;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    d = q;
    d.on_key_prev = ON_KEY_INPUT_I;
    d.pc_clear = 1'b0;
    d.irq_take = 1'b0;
    d.out_prech = 1'b0;

    // sequencer
    case (q.state)
      standby_wake_pkg::ST_RUN: begin
        if (bus_step) begin
          d.phase = ~q.phase;
          d.out_prech = INSTR_LAST_I;
          if (q.phase && SLEEP_INSTRUCTION_I) begin
            d.state = standby_wake_pkg::ST_SLEEP_CMD;
            d.phase = 1'b0;
          end else if (q.phase && INSTR_LAST_I && HALT_REQUEST_I) begin
            d.state = standby_wake_pkg::ST_HALTED;
          end
        end
      end
      standby_wake_pkg::ST_SLEEP_CMD: begin
        if (bus_step) begin
          d.phase = ~q.phase;
          if (q.phase) begin
            d.state = standby_wake_pkg::ST_STANDBY;
            d.lvl_cnt = '0;
            d.wake_pend = 1'b0;
          end
        end
      end
      standby_wake_pkg::ST_STANDBY: begin
        // level sources count only while asleep, from zero, so sleeping on one wakes after the full interval
        if (lvl_src) begin
          if (q.lvl_cnt != 6'(standby_wake_pkg::WAKE_MIN_CYCLES)) begin
            d.lvl_cnt = q.lvl_cnt + 6'h01;
          end
        end else begin
          d.lvl_cnt = '0;
        end
        if (on_edge) begin
          d.wake_pend = 1'b1;
          d.woke_on_key = 1'b1;
        end
        if (q.lvl_cnt == 6'(standby_wake_pkg::WAKE_MIN_CYCLES - 1) && lvl_src) begin
          d.wake_pend = 1'b1;
        end
        if (q.wake_pend && !HALT_REQUEST_I) begin
          d.state = standby_wake_pkg::ST_PWR_WAIT;
          d.tmo_cnt = '0;
        end
      end
      standby_wake_pkg::ST_PWR_WAIT: begin
        if (SUPPLY_READY_I) begin
          d.state = standby_wake_pkg::ST_CLK_WAIT;
        end else if (TIMER_RUNNING_I) begin
          d.tmo_cnt = q.tmo_cnt + 32'h1;
          if (q.tmo_cnt == 32'(WAKE_TIMEOUT_CYCLES - 1)) begin
            d.state = standby_wake_pkg::ST_STANDBY;
            d.wake_pend = 1'b0;
            d.woke_on_key = 1'b0;
            d.lvl_cnt = '0;
            d.hw_status[standby_wake_pkg::HW_TIMEOUT_BIT] = 1'b1;
          end
        end
      end
      standby_wake_pkg::ST_CLK_WAIT: begin
        if (FAST_OSC_PULSES_I) begin
          d.state = standby_wake_pkg::ST_FIRST_CMD;
          d.phase = 1'b0;
          if (q.reset_seen) begin
            d.pc_clear = 1'b1;
            d.hex_mode = 1'b1;
            d.hw_status[standby_wake_pkg::HW_RESETWAKE_BIT] = 1'b1;
          end
        end
      end
      standby_wake_pkg::ST_FIRST_CMD: begin
        if (bus_step) begin
          d.phase = ~q.phase;
          if (q.phase) begin
            d.state = standby_wake_pkg::ST_PC_CMD;
            d.reset_seen = 1'b0;
          end
        end
      end
      standby_wake_pkg::ST_PC_CMD: begin
        if (bus_step) begin
          d.phase = ~q.phase;
          if (q.phase) begin
            d.state = standby_wake_pkg::ST_RUN;
            d.wake_pend = 1'b0;
            d.woke_on_key = 1'b0;
            if (irq_src) begin
              d.irq_take = 1'b1;
            end
          end
        end
      end
      standby_wake_pkg::ST_HALTED: begin
        // no interrupt is taken until the halt level drops
        if (!HALT_REQUEST_I) begin
          d.state = standby_wake_pkg::ST_RUN;
          d.phase = 1'b0;
          d.irq_take = irq_src;
        end
      end
      default: begin
        d.state = standby_wake_pkg::ST_STANDBY;
      end
    endcase

    // taking an interrupt enters the routine
    if (d.irq_take) begin
      d.int_enable = 1'b0;
      d.key_sm_busy = 1'b1;
    end

    // register writes
    if (apb_wr) begin
      case (PADDR_I)
        standby_wake_pkg::OFS_CTRL: begin
          d.key_irq_unmask = PWDATA_I[standby_wake_pkg::CTRL_UNMASK_BIT];
          d.int_enable = PWDATA_I[standby_wake_pkg::CTRL_INTEN_BIT];
          d.hex_mode = PWDATA_I[standby_wake_pkg::CTRL_HEX_BIT];
          if (PWDATA_I[standby_wake_pkg::CTRL_KEYSM_CLR_BIT]) begin
            d.key_sm_busy = 1'b0;
          end
        end
        standby_wake_pkg::OFS_HWSTAT: begin
          // write one clears, a same-cycle set of a clear bit still wins
          d.hw_status = (q.hw_status & ~PWDATA_I[1:0]) | (d.hw_status & ~q.hw_status);
        end
        standby_wake_pkg::OFS_OUTREG: begin
          d.out_reg = PWDATA_I[11:0] & standby_wake_pkg::OUTREG_USED_MASK;
        end
        default: begin
        end
      endcase
    end

    // external reset input shuts the core down and clears status
    if (!RESET_IN_N_I) begin
      d.state = standby_wake_pkg::ST_STANDBY;
      d.phase = 1'b0;
      d.wake_pend = 1'b0;
      d.woke_on_key = 1'b0;
      d.lvl_cnt = '0;
      d.reset_seen = 1'b1;
      d.int_enable = 1'b1;
      d.key_irq_unmask = 1'b1;
      d.key_sm_busy = 1'b0;
      d.hw_status = '0;
      d.return_stack_ptr = standby_wake_pkg::RETURN_STACK_PTR_RESET;
      d.irq_take = 1'b0;
      d.pc_clear = 1'b0;
    end

    // pin drive follows the next state; parked is the reset condition
    d.strobe_n = 1'b1;
    d.strobe_oe = 1'b0;
    d.cmd_n = 1'b1;
    d.cmd_oe = 1'b0;
    d.nib = '0;
    d.nib_oe = 1'b0;
    d.bus_float = 1'b1;
    d.prech_n = 1'b1;
    d.clk_req = 1'b0;
    d.sleep_ind = 1'b0;
    d.wake_req = 1'b0;
    d.poll_en_n = HALT_REQUEST_I;
    if (bus_state(d.state)) begin
      d.bus_float = 1'b0;
      d.clk_req = 1'b1;
      d.strobe_oe = 1'b1;
      d.cmd_oe = 1'b1;
      d.prech_n = d.phase;
      d.strobe_n = ~d.phase;
      if (d.state != standby_wake_pkg::ST_RUN) begin
        d.cmd_n = ~d.phase;
        d.nib = cmd_code(d.state, d.reset_seen);
        d.nib_oe = 1'b1;
        d.sleep_ind = (d.state == standby_wake_pkg::ST_SLEEP_CMD);
      end
    end else if (d.state == standby_wake_pkg::ST_HALTED) begin
      d.clk_req = 1'b1;
    end else if (d.state == standby_wake_pkg::ST_CLK_WAIT) begin
      d.clk_req = 1'b1;
    end else if (d.state == standby_wake_pkg::ST_PWR_WAIT) begin
      d.wake_req = 1'b1;
    end

    // apb answer, ready in the first access cycle
    d.pready = PSEL_I & ~PENABLE_I;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (PSEL_I && !PENABLE_I) begin
      case (PADDR_I)
        standby_wake_pkg::OFS_CTRL: begin
          d.prdata[standby_wake_pkg::CTRL_UNMASK_BIT] = q.key_irq_unmask;
          d.prdata[standby_wake_pkg::CTRL_INTEN_BIT] = q.int_enable;
          d.prdata[standby_wake_pkg::CTRL_HEX_BIT] = q.hex_mode;
        end
        standby_wake_pkg::OFS_STATUS: begin
          d.prdata[7:0] = q.state;
          d.prdata[standby_wake_pkg::STAT_WAKE_BIT] = q.wake_pend;
          d.prdata[standby_wake_pkg::STAT_RSEEN_BIT] = q.reset_seen;
          d.prdata[standby_wake_pkg::STAT_KEYSM_BIT] = q.key_sm_busy;
        end
        standby_wake_pkg::OFS_HWSTAT: begin
          d.prdata[1:0] = q.hw_status;
        end
        standby_wake_pkg::OFS_OUTREG: begin
        end
        standby_wake_pkg::OFS_INREG: begin
          d.prdata[8:0] = KEY_SENSE_LINES_I;
          d.prdata[standby_wake_pkg::INREG_ON_BIT] = ON_KEY_INPUT_I;
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end

    // synchronous power-on reset of the whole record
    if (RST_I) begin
      d = '0;
      d.state = standby_wake_pkg::ST_STANDBY;
      d.int_enable = 1'b1;
      d.key_irq_unmask = 1'b1;
      d.reset_seen = 1'b1;
      d.return_stack_ptr = standby_wake_pkg::RETURN_STACK_PTR_RESET;
      d.out_reg = standby_wake_pkg::OUTREG_RESET;
      d.strobe_n = 1'b1;
      d.cmd_n = 1'b1;
      d.bus_float = 1'b1;
      d.prech_n = 1'b1;
    end
  end

  // state register
  always_ff @(posedge CLOCK_I) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the state register
  assign PRDATA_O = q.prdata;
  assign PREADY_O = q.pready;
  assign PSLVERR_O = q.pslverr;
  assign STROBE_OUT_N_O = q.strobe_n;
  assign STROBE_OE_O = q.strobe_oe;
  assign CMD_DATA_OUT_N_O = q.cmd_n;
  assign CMD_DATA_OE_O = q.cmd_oe;
  assign NIBBLE_BUS_LINES_O = q.nib;
  assign NIBBLE_BUS_OE_O = q.nib_oe;
  assign BUS_FLOAT_O = q.bus_float;
  assign BUS_PRECHARGE_N_O = q.prech_n;
  assign CLOCK_REQUEST_O = q.clk_req;
  assign KEY_POLL_ENABLE_N_O = q.poll_en_n;
  assign SLEEP_INDICATOR_O = q.sleep_ind;
  assign WAKE_REQUEST_O = q.wake_req;
  assign IRQ_TAKE_O = q.irq_take;
  assign PC_CLEAR_O = q.pc_clear;
  assign HEX_MODE_O = q.hex_mode;
  assign KEY_IRQ_UNMASK_O = q.key_irq_unmask;
  assign INT_ENABLE_O = q.int_enable;
  assign RETURN_STACK_PTR_O = q.return_stack_ptr;
  assign OUT_REG_O = q.out_reg;
  assign OUT_PRECHARGE_O = q.out_prech;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  AST_RESET_PARKS: assert property (
    !RESET_IN_N_I |=> !q.strobe_oe && !q.cmd_oe && !q.nib_oe && q.bus_float && q.prech_n
      && !q.clk_req && !q.sleep_ind)
    else $error("reset input did not park the bus pins");
  AST_RESET_INIT: assert property (
    !RESET_IN_N_I |=> q.int_enable && q.key_irq_unmask && q.return_stack_ptr == 3'h0
      && q.hw_status == 2'h0 && !q.key_sm_busy)
    else $error("reset input did not initialise control state");
  AST_NO_WAKE_IN_RESET: assert property (
    !RESET_IN_N_I [*2] |-> q.state == standby_wake_pkg::ST_STANDBY && !q.wake_pend)
    else $error("core awake or wake latched under reset input");
  AST_SLEEP_SEQ: assert property (
    q.state == standby_wake_pkg::ST_SLEEP_CMD && q.phase && !WAIT_REQUEST_I && RESET_IN_N_I
      |=> q.state == standby_wake_pkg::ST_STANDBY && !q.strobe_oe)
    else $error("sleep command not followed by standby");
  AST_SLEEP_IND: assert property (
    q.sleep_ind |-> q.state == standby_wake_pkg::ST_SLEEP_CMD && q.nib == 4'h3)
    else $error("sleep indicator outside sleep command");
  AST_HALT_DEFER: assert property (
    q.state == standby_wake_pkg::ST_STANDBY && HALT_REQUEST_I
      |=> q.state == standby_wake_pkg::ST_STANDBY)
    else $error("wake left standby while halt held");
  AST_CLK_FIRST: assert property (
    q.state == standby_wake_pkg::ST_CLK_WAIT && !FAST_OSC_PULSES_I && RESET_IN_N_I
      |=> q.state == standby_wake_pkg::ST_CLK_WAIT && q.clk_req && !q.strobe_oe)
    else $error("bus command before oscillator pulses");
  AST_PC_AFTER_FIRST: assert property (
    q.state == standby_wake_pkg::ST_FIRST_CMD && q.phase && !WAIT_REQUEST_I && RESET_IN_N_I
      |=> q.state == standby_wake_pkg::ST_PC_CMD ##1 q.nib == 4'h2 [*1])
    else $error("program counter broadcast missing after first command");
  AST_WAIT_HOLD: assert property (
    bus_state(q.state) && q.phase && WAIT_REQUEST_I && RESET_IN_N_I
      |=> $stable(q.state) && $stable(q.strobe_n) && $stable(q.nib) && $stable(q.prech_n))
    else $error("bus condition changed during wait");
  AST_HALT_IDLE: assert property (
    q.state == standby_wake_pkg::ST_HALTED |-> q.bus_float && q.prech_n && q.clk_req
      && !q.strobe_oe && !q.cmd_oe)
    else $error("halted idle pins wrong");
  AST_PRECH_BEFORE_STROBE: assert property (
    $fell(q.strobe_n) |-> $past(!q.prech_n))
    else $error("strobe fell without preceding precharge pulse");
  AST_OUT_UNUSED: assert property (
    q.out_reg[10:9] == 2'h0)
    else $error("unused output register bits stored");
  AST_NO_RUN_UNPERMITTED: assert property (
    q.state == standby_wake_pkg::ST_PWR_WAIT && !SUPPLY_READY_I
      |=> q.state != standby_wake_pkg::ST_CLK_WAIT)
    else $error("core ran without supply permission");

endmodule : cpu_standby_wake_control

// *** design/standby_wake_pkg.sv ***
// constants, types and state record of the standby and wake controller
package standby_wake_pkg;

  // one-hot sequencer states
  typedef enum logic [7:0] {
    ST_RUN = 8'h01,
    ST_SLEEP_CMD = 8'h02,
    ST_STANDBY = 8'h04,
    ST_PWR_WAIT = 8'h08,
    ST_CLK_WAIT = 8'h10,
    ST_FIRST_CMD = 8'h20,
    ST_PC_CMD = 8'h40,
    ST_HALTED = 8'h80
  } state_t;

  // bus command codes on the nibble lines
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESET = 4'h1;
  localparam logic [3:0] CMD_PC_LOAD = 4'h2;
  localparam logic [3:0] CMD_SLEEP = 4'h3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_HWSTAT = 8'h08;
  localparam logic [7:0] OFS_OUTREG = 8'h0C;
  localparam logic [7:0] OFS_INREG = 8'h10;

  // control register fields
  localparam int CTRL_UNMASK_BIT = 0;
  localparam int CTRL_INTEN_BIT = 1;
  localparam int CTRL_HEX_BIT = 2;
  localparam int CTRL_KEYSM_CLR_BIT = 3;
  // status register fields
  localparam int STAT_WAKE_BIT = 8;
  localparam int STAT_RSEEN_BIT = 9;
  localparam int STAT_KEYSM_BIT = 10;
  // hardware status fields
  localparam int HW_TIMEOUT_BIT = 0;
  localparam int HW_RESETWAKE_BIT = 1;
  // output and input register layout
  localparam logic [11:0] OUTREG_USED_MASK = 12'h9FF;
  localparam int INREG_ON_BIT = 15;

  // reset values
  localparam logic [11:0] OUTREG_RESET = 12'h000;
  localparam logic [2:0] RETURN_STACK_PTR_RESET = 3'h0;

  // timing
  localparam int CLOCK_HZ = 25000000;
  localparam int WAKE_MIN_CYCLES = 32;
  localparam int WAKE_TIMEOUT_MS = 2000;
  localparam int WAKE_TIMEOUT_CYCLES = WAKE_TIMEOUT_MS * (CLOCK_HZ / 1000);

  // whole state of the controller
  typedef struct packed {
    state_t state;
    logic phase;
    logic wake_pend;
    logic reset_seen;
    logic woke_on_key;
    logic [5:0] lvl_cnt;
    logic [31:0] tmo_cnt;
    logic on_key_prev;
    logic int_enable;
    logic key_irq_unmask;
    logic key_sm_busy;
    logic [1:0] hw_status;
    logic [2:0] return_stack_ptr;
    logic hex_mode;
    logic pc_clear;
    logic [11:0] out_reg;
    logic out_prech;
    logic strobe_n;
    logic strobe_oe;
    logic cmd_n;
    logic cmd_oe;
    logic [3:0] nib;
    logic nib_oe;
    logic bus_float;
    logic prech_n;
    logic clk_req;
    logic poll_en_n;
    logic sleep_ind;
    logic wake_req;
    logic irq_take;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ctl_t;

endpackage : standby_wake_pkg

// *** dv/supply_osc_model.sv ***
// far-side model: power supply, fast oscillator and a slow peripheral
`timescale 1ns/1ps
module supply_osc_model (
  input wire logic clk_i,
  input wire logic wake_req_i,
  input wire logic clk_req_i,
  input wire logic strobe_n_i,
  input wire logic refuse_i,
  input wire logic stall_i,
  output logic ready_o = 1'b0,
  output logic osc_o = 1'b0,
  output logic wait_o
);
  logic [2:0] reg_cnt = 3'h0;
  logic held = 1'b0;

  // supply regulates for some cycles, then grants the run unless refusing
  always @(posedge clk_i) begin
    reg_cnt <= wake_req_i ? reg_cnt + {2'h0, reg_cnt != 3'h7} : 3'h0;
    ready_o <= wake_req_i && !refuse_i && reg_cnt == 3'h7;
  end

  // oscillator starts one cycle after the request
  always @(posedge clk_i) osc_o <= clk_req_i;

  // slow peripheral stretches each strobe-low cycle once, answering inside that cycle
  assign wait_o = stall_i && !strobe_n_i && !held;
  always @(posedge clk_i) held <= wait_o;
endmodule : supply_osc_model

// *** dv/test_cpu_standby_wake_control.sv ***
// self-checking bench of the standby and wake controller
`timescale 1ns/1ps
module test_cpu_standby_wake_control;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rdat;
  logic rin_n = 1'b1, halt = 1'b0, keyd = 1'b0, burn = 1'b0, cds = 1'b1, onk = 1'b0;
  logic tmr = 1'b0, slp = 1'b0, last = 1'b0, refuse = 1'b0, stall = 1'b0, rerr;
  logic [8:0] keys = 9'h000;
  logic wt, osc, rdy, prdy, perr, stb_n, stb_oe, cmd_n, cmd_oe, nib_oe, bfl, pre_n, clock_request;
  logic poll_n, sind, wreq, irq, pcc, hex, unm, ien, opre;
  logic [3:0] nib;
  logic [2:0] rsp;
  logic [11:0] oreg;
  logic [6:0] cmds[$];
  logic pcc_seen = 1'b0, opre_seen = 1'b0, wt_q = 1'b0, pre_q = 1'b1;
  logic [5:0] bus_q = 6'h3F;
  int fails = 0, compares = 0, irqs = 0;

  always #20 clk = ~clk;

  cpu_standby_wake_control #(.WAKE_TIMEOUT_CYCLES(20)) uut (
    .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .RESET_IN_N_I(rin_n), .HALT_REQUEST_I(halt), .WAIT_REQUEST_I(wt),
    .KEY_DOWN_EVENT_I(keyd), .BURNIN_WAKE_I(burn), .COMMAND_DATA_SELECT_I(cds),
    .ON_KEY_INPUT_I(onk), .FAST_OSC_PULSES_I(osc), .SUPPLY_READY_I(rdy),
    .TIMER_RUNNING_I(tmr), .SLEEP_INSTRUCTION_I(slp), .INSTR_LAST_I(last),
    .KEY_SENSE_LINES_I(keys), .STROBE_OUT_N_O(stb_n), .STROBE_OE_O(stb_oe),
    .CMD_DATA_OUT_N_O(cmd_n), .CMD_DATA_OE_O(cmd_oe), .NIBBLE_BUS_LINES_O(nib),
    .NIBBLE_BUS_OE_O(nib_oe), .BUS_FLOAT_O(bfl), .BUS_PRECHARGE_N_O(pre_n),
    .CLOCK_REQUEST_O(clock_request), .KEY_POLL_ENABLE_N_O(poll_n), .SLEEP_INDICATOR_O(sind),
    .WAKE_REQUEST_O(wreq), .IRQ_TAKE_O(irq), .PC_CLEAR_O(pcc), .HEX_MODE_O(hex),
    .KEY_IRQ_UNMASK_O(unm), .INT_ENABLE_O(ien), .RETURN_STACK_PTR_O(rsp),
    .OUT_REG_O(oreg), .OUT_PRECHARGE_O(opre));

  supply_osc_model pm (.clk_i(clk), .wake_req_i(wreq), .clk_req_i(clock_request), .strobe_n_i(stb_n),
    .refuse_i(refuse), .stall_i(stall), .ready_o(rdy), .osc_o(osc), .wait_o(wt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // one apb transfer, pready sampled at rising edges, data taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rdat = prd;
    rerr = perr;
    if (prdy !== 1'b1) fails++;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask : apb

  // poll the state field until it shows the wanted state
  task automatic wst(input logic [7:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, standby_wake_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rdat[7:0] !== s && n < 100);
    chk({24'h0, rdat[7:0]}, {24'h0, s});
    @(posedge clk);
  endtask : wst

  // wait until k bus commands have been seen
  task automatic wcmd(input int k);
    int n;
    n = 0;
    while (cmds.size() < k && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (cmds.size() < k) fails++;
    @(posedge clk);
  endtask : wcmd

  task automatic parked(input logic cr);
    @(negedge clk);
    chk({stb_oe, cmd_oe, nib_oe, bfl, pre_n, clock_request}, {5'b00011, cr});
  endtask : parked

  // bus monitor: freeze under wait, command capture, pulse flags
  always @(negedge clk) begin
    if (wt_q) chk({26'h0, stb_n, cmd_n, nib}, {26'h0, bus_q});
    if (stb_oe && !stb_n && !cmd_n && bus_q[5]) cmds.push_back({pre_q, clock_request, sind, nib});
    if (irq) irqs++;
    pcc_seen = pcc_seen | pcc;
    opre_seen = opre_seen | opre;
    wt_q = wt;
    pre_q = pre_n;
    bus_q = {stb_n, cmd_n, nib};
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    parked(1'b0);
    chk({ien, unm, rsp}, 5'b11000);
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    onk <= 1'b1;
    @(posedge clk);
    onk <= 1'b0;
    stall <= 1'b1;
    wst(standby_wake_pkg::ST_STANDBY);
    chk({rdat[8], poll_n}, 2'b11);
    halt <= 1'b0;
    wcmd(2);
    chk(cmds[0], {3'b010, standby_wake_pkg::CMD_RESET});
    chk(cmds[1], {3'b010, standby_wake_pkg::CMD_PC_LOAD});
    chk({pcc_seen, hex, irqs[1:0]}, 4'b1100);
    wst(standby_wake_pkg::ST_RUN);
    stall <= 1'b0;
    apb(1'b1, standby_wake_pkg::OFS_OUTREG, 32'hFFFFFFFF);
    chk(oreg, standby_wake_pkg::OUTREG_USED_MASK);
    apb(1'b0, standby_wake_pkg::OFS_OUTREG, 32'h0);
    chk(rdat, 32'h0);
    @(posedge clk);
    keys <= 9'h1A5;
    onk <= 1'b1;
    apb(1'b0, standby_wake_pkg::OFS_INREG, 32'h0);
    chk(rdat, 32'h000081A5);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    @(posedge clk);
    halt <= 1'b1;
    last <= 1'b1;
    onk <= 1'b0;
    keyd <= 1'b1;
    wst(standby_wake_pkg::ST_HALTED);
    parked(1'b1);
    chk(opre_seen, 1'b1);
    chk(irqs, 0);
    @(posedge clk);
    halt <= 1'b0;
    last <= 1'b0;
    slp <= 1'b1;
    wcmd(3);
    chk(cmds[2], {3'b011, standby_wake_pkg::CMD_SLEEP});
    chk(irqs, 1);
    // restore unmask, enable and hex mode, release the key interrupt machine
    apb(1'b1, standby_wake_pkg::OFS_CTRL, 32'h0000000F);
    @(posedge clk);
    slp <= 1'b0;
    keyd <= 1'b1;
    wst(standby_wake_pkg::ST_STANDBY);
    parked(1'b0);
    @(posedge clk);
    keyd <= 1'b0;
    wst(standby_wake_pkg::ST_STANDBY);
    chk(rdat[8], 1'b0);
    keyd <= 1'b1;
    wcmd(5);
    chk(cmds[3], {3'b010, standby_wake_pkg::CMD_NOP});
    wst(standby_wake_pkg::ST_RUN);
    chk(irqs, 2);
    keyd <= 1'b0;
    burn <= 1'b1;
    slp <= 1'b1;
    wcmd(7);
    slp <= 1'b0;
    wcmd(8);
    chk(cmds[6][3:0], standby_wake_pkg::CMD_NOP);
    burn <= 1'b0;
    rin_n <= 1'b0;
    onk <= 1'b1;
    repeat (3) @(posedge clk);
    rin_n <= 1'b1;
    onk <= 1'b0;
    wst(standby_wake_pkg::ST_STANDBY);
    chk(rdat[9:8], 2'b10);
    refuse <= 1'b1;
    tmr <= 1'b1;
    onk <= 1'b1;
    wst(standby_wake_pkg::ST_PWR_WAIT);
    onk <= 1'b0;
    wst(standby_wake_pkg::ST_STANDBY);
    apb(1'b0, standby_wake_pkg::OFS_HWSTAT, 32'h0);
    chk(rdat[0], 1'b1);
    parked(1'b0);
    chk(cmds.size(), 8);
    summarize();
  end

  // watchdog far beyond the expected run length
  initial begin
    #(40 * 30000);
    fails++;
    summarize();
  end
endmodule : test_cpu_standby_wake_control
